// file: include/crb_pkg.sv
// crb_pkg: constants and register table of the configuration register bank
package crb_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CRB_CLK_HZ        = 40_000_000;
  localparam int CRB_POR_BLOCK_US  = 500;
  localparam int CRB_POR_BLOCK_CYC = CRB_POR_BLOCK_US * (CRB_CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // configuration port keys and fixed indexes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CRB_KEY_ENTER   = 8'h55;
  localparam logic [7:0] CRB_KEY_EXIT    = 8'hAA;
  localparam logic [7:0] CRB_IDX_CTRL    = 8'h02;
  localparam logic [7:0] CRB_IDX_LDN     = 8'h07;
  localparam logic [7:0] CRB_IDX_ID      = 8'h20;
  localparam logic [7:0] CRB_IDX_REV     = 8'h21;
  localparam logic [7:0] CRB_IDX_BASE_LO = 8'h26;
  localparam logic [7:0] CRB_IDX_BASE_HI = 8'h27;
  localparam logic [7:0] CRB_IDX_FIO_HI  = 8'h60;
  localparam logic [7:0] CRB_IDX_FIO_LO  = 8'h61;
  localparam logic [7:0] CRB_BASE_LO_S0  = 8'hF0;  // strap low
  localparam logic [7:0] CRB_BASE_LO_S1  = 8'h70;  // strap high
  localparam logic [7:0] CRB_BASE_HI_RST = 8'h03;
  localparam logic [7:0] CRB_LD_FLOPPY   = 8'h00;
  localparam logic [7:0] CRB_LD_RSVD     = 8'h01;
  localparam int         CRB_SOFT_BIT    = 0;

  // ----------------------------------------------------------------------
  // register table: index, reset value, reset class
  // ----------------------------------------------------------------------
  localparam int CRB_NREG     = 24;
  localparam int CRB_CLS_HARD = 0;  // hard reset and main power-on
  localparam int CRB_CLS_VTR  = 1;  // standby power-on
  localparam int CRB_CLS_SOFT = 2;  // soft reset
  localparam int CRB_CLS_LD0  = 3;  // lives in the floppy unit bank
  localparam int CRB_CLS_WO   = 4;  // write only, reads zero

  localparam logic [7:0] CRB_REG_IDX [CRB_NREG] = '{
    8'h02, 8'h03, 8'h07, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h28,
    8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F,
    8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1, 8'hF2, 8'hF4, 8'hF5};
  localparam logic [7:0] CRB_REG_RST [CRB_NREG] = '{
    8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04, 8'hF0, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h03, 8'hF0, 8'h06, 8'h02, 8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00};
  localparam logic [7:0] CRB_REG_CLS [CRB_NREG] = '{
    8'h13, 8'h03, 8'h07, 8'h07, 8'h03, 8'h03, 8'h01, 8'h01, 8'h05,
    8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
    8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0B, 8'h0B, 8'h0B, 8'h0B, 8'h0B};

  // table positions of registers that steer outputs
  localparam int CRB_POS_LDN     = 2;
  localparam int CRB_POS_BASE_LO = 6;
  localparam int CRB_POS_BASE_HI = 7;
  localparam int CRB_POS_ACT     = 14;
  localparam int CRB_POS_FIO_HI  = 15;
  localparam int CRB_POS_FIO_LO  = 16;
  localparam int CRB_POS_IRQ     = 17;
  localparam int CRB_POS_DMA     = 18;

endpackage

// file: design/crb_por_blank.sv
// crb_por_blank: holds off host access for a fixed count after main power-on
`timescale 1ns/10ps
module crb_por_blank #(
  parameter int CYCLES = 20000
) (
  // clock and reset
  input  logic sys_clk,
  input  logic rstn,
  // status
  output logic blocked
);
  localparam int CW = $clog2(CYCLES + 1);

  initial begin
    if (CYCLES < 1) $error("crb_por_blank: CYCLES must be at least 1");
  end

  logic [CW-1:0] cnt_q;
  logic          blocked_q;

  // ----------------------------------------------------------------------
  // counter runs only after the main power-on, never after other resets
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= '0;
      blocked_q <= 1'b1;
    end else if (blocked_q) begin
      cnt_q <= cnt_q + CW'(1);
      if (cnt_q == CW'(CYCLES - 1)) begin
        blocked_q <= 1'b0;
      end
    end
  end

  assign blocked = blocked_q;
endmodule // crb_por_blank

// file: design/crb_port_decode.sv
// crb_port_decode: configuration key, index port and data port decoding
`timescale 1ns/10ps
module crb_port_decode (
  // clock and reset
  input  logic        sys_clk,
  input  logic        rstn,
  input  logic        mode_clr,
  // host i/o cycle, already gated by the power-on hold-off
  input  logic [15:0] io_addr,
  input  logic        aen,
  input  logic        io_wr,
  input  logic        io_rd,
  input  logic [7:0]  io_wdata,
  input  logic [15:0] port_base,
  // decoded results
  output logic        cfg_mode,
  output logic [7:0]  index_q,
  output logic        data_wr,
  output logic        data_rd,
  output logic        index_rd
);
  import crb_pkg::*;

  logic at_index;
  logic at_data;
  logic mode_q;

  // address decode; aen high marks a dma cycle that must not hit us
  assign at_index = !aen && (io_addr == port_base);
  assign at_data  = !aen && (io_addr == 16'(port_base + 16'h0001));

  // ----------------------------------------------------------------------
  // run / configuration state; 0x55 enters, 0xAA leaves
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= 1'b0;
    end else if (mode_clr) begin
      mode_q <= 1'b0;
    end else if (io_wr && at_index) begin
      if (!mode_q && io_wdata == CRB_KEY_ENTER) begin
        mode_q <= 1'b1;
      end else if (mode_q && io_wdata == CRB_KEY_EXIT) begin
        mode_q <= 1'b0;
      end
    end
  end

  // index pointer shares the key address while in configuration state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      index_q <= 8'h00;
    end else if (mode_clr) begin
      index_q <= 8'h00;
    end else if (io_wr && at_index && mode_q && io_wdata != CRB_KEY_EXIT) begin
      index_q <= io_wdata;
    end
  end

  // index and data ports answer only in configuration state
  assign data_wr  = io_wr && at_data && mode_q;
  assign data_rd  = io_rd && at_data && mode_q;
  assign index_rd = io_rd && at_index && mode_q;
  assign cfg_mode = mode_q;
endmodule // crb_port_decode

// file: design/crb_top.sv
// crb_top: global and floppy unit configuration register bank
//
// Notes on behaviour
// - for 500 us after main power-on every host access is ignored.
// - index 0x20 reads a fixed part identification byte, writes do nothing.
// - index 0x21 reads a fixed revision byte, writes do nothing.
// - index 0x26 resets to 0xF0 with strap low and 0x70 with strap high, on hard and main resets.
// - index 0x27 resets to 0x03 on hard and main resets only, other resets leave it.
// - indexes 0x60 and 0x61 reset to 0x03 and 0xF0 on main, hard, standby and soft resets and are writable.
// - logical device 1 is reserved and has no registers.
// - writing 0x55 to the configuration port enters configuration mode, 0xAA leaves it.
// - index 0x07 selects the logical device bank, data port sits one above the index port.
// - writing bit 0 of the control register as one makes a soft reset of soft-reset registers.
`timescale 1ns/10ps
module crb_top
  import crb_pkg::*;
#(
  parameter int         POR_BLOCK_CYCLES = crb_pkg::CRB_POR_BLOCK_CYC,
  parameter logic [7:0] PART_ID          = 8'hA5,  // arbitrary value
  parameter logic [7:0] PART_REV         = 8'h13   // arbitrary value
) (
  // clock and reset sources
  input  logic        sys_clk,
  input  logic        rstn,
  input  logic        host_hard_reset_in,
  input  logic        vtr_por_in,
  input  logic        base_select_strap,
  // host i/o bus
  input  logic [15:0] io_addr,
  input  logic        aen,
  input  logic        io_wr,
  input  logic        io_rd,
  input  logic [7:0]  io_wdata,
  output logic [7:0]  io_rdata,
  output logic        io_rdata_valid,
  // status
  output logic        cfg_mode,
  output logic        host_blocked,
  output logic [15:0] config_port_base,
  // floppy unit settings
  output logic        floppy_unit_active,
  output logic [15:0] floppy_io_base,
  output logic [7:0]  floppy_irq_select,
  output logic [7:0]  floppy_dma_select
);
  import crb_pkg::*;

  initial begin
    if (POR_BLOCK_CYCLES < 1) $error("crb_top: POR_BLOCK_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------------
  logic       por_pend_q;
  logic       soft_q;
  logic       mode_clr;
  logic [7:0] strap_rst;
  logic [7:0] reg_q [CRB_NREG];
  logic       blk;
  logic       g_wr;
  logic       g_rd;
  logic [7:0] index_q;
  logic       data_wr;
  logic       data_rd;
  logic       index_rd;
  logic [7:0] rd_val;
  logic [7:0] rdata_q;
  logic       rvalid_q;

  // the strap cannot be loaded under the asynchronous reset, so the first
  // cycle after release reloads strap-dependent registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_pend_q <= 1'b1;
    end else begin
      por_pend_q <= 1'b0;
    end
  end

  // strap value followed while hard reset is held, last one sticks
  assign strap_rst = base_select_strap ? CRB_BASE_LO_S1 : CRB_BASE_LO_S0;

  // hard and standby resets return the port to run state
  assign mode_clr = host_hard_reset_in | vtr_por_in | por_pend_q;

  // soft reset pulse, one cycle after the control write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= data_wr && index_q == CRB_IDX_CTRL && io_wdata[CRB_SOFT_BIT]
                && !mode_clr;
    end
  end

  // ----------------------------------------------------------------------
  // power-on hold-off and port decode
  // ----------------------------------------------------------------------
  crb_por_blank #(
    .CYCLES (POR_BLOCK_CYCLES)
  ) u_blank (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .blocked (blk)
  );

  // accesses during hold-off are dropped before any decode
  assign g_wr = io_wr && !blk;
  assign g_rd = io_rd && !blk;

  crb_port_decode u_port (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .mode_clr  (mode_clr),
    .io_addr   (io_addr),
    .aen       (aen),
    .io_wr     (g_wr),
    .io_rd     (g_rd),
    .io_wdata  (io_wdata),
    .port_base (config_port_base),
    .cfg_mode  (cfg_mode),
    .index_q   (index_q),
    .data_wr   (data_wr),
    .data_rd   (data_rd),
    .index_rd  (index_rd)
  );

  // ----------------------------------------------------------------------
  // register storage, one entry per table row
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < CRB_NREG; g++) begin : g_reg
    localparam logic [7:0] CLS = CRB_REG_CLS[g];
    logic       hit_rst;
    logic       hit_wr;
    logic [7:0] rst_val;

    // only the base low byte follows the strap
    assign rst_val = (CRB_REG_IDX[g] == CRB_IDX_BASE_LO) ? strap_rst : CRB_REG_RST[g];
    // each register sees the first cycle after main reset plus the reset sources its class lists
    assign hit_rst = por_pend_q
                   | (CLS[CRB_CLS_HARD] & host_hard_reset_in)
                   | (CLS[CRB_CLS_VTR]  & vtr_por_in)
                   | (CLS[CRB_CLS_SOFT] & soft_q);
    // bank registers answer only for the floppy unit bank
    assign hit_wr  = data_wr && index_q == CRB_REG_IDX[g]
                   && (!CLS[CRB_CLS_LD0] || reg_q[CRB_POS_LDN] == CRB_LD_FLOPPY);

    // reset beats a write landing in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        reg_q[g] <= CRB_REG_RST[g];
      end else if (hit_rst) begin
        reg_q[g] <= rst_val;
      end else if (hit_wr) begin
        reg_q[g] <= io_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // anything not matched falls through to zero
  always_comb begin
    rd_val = 8'h00;
    if (index_q == CRB_IDX_ID) begin
      rd_val = PART_ID;
    end else if (index_q == CRB_IDX_REV) begin
      rd_val = PART_REV;
    end else begin
      for (int i = 0; i < CRB_NREG; i++) begin
        if (index_q == CRB_REG_IDX[i] && !CRB_REG_CLS[i][CRB_CLS_WO]
            && (!CRB_REG_CLS[i][CRB_CLS_LD0]
                || reg_q[CRB_POS_LDN] == CRB_LD_FLOPPY)) begin
          rd_val = reg_q[i];
        end
      end
    end
  end

  // read data is registered and marked valid one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= data_rd | index_rd;
      if (data_rd) begin
        rdata_q <= rd_val;
      end else if (index_rd) begin
        rdata_q <= index_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign io_rdata           = rdata_q;
  assign io_rdata_valid     = rvalid_q;
  assign host_blocked       = blk;
  assign config_port_base   = {reg_q[CRB_POS_BASE_HI], reg_q[CRB_POS_BASE_LO]};
  assign floppy_unit_active = reg_q[CRB_POS_ACT][0];
  assign floppy_io_base     = {reg_q[CRB_POS_FIO_HI], reg_q[CRB_POS_FIO_LO]};
  assign floppy_irq_select  = reg_q[CRB_POS_IRQ];
  assign floppy_dma_select  = reg_q[CRB_POS_DMA];

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic cfg_key_wr;
  assign cfg_key_wr = io_wr && !aen && io_addr == config_port_base;

  a_blank_no_entry: assert property (
    blk && cfg_key_wr && !cfg_mode |=> !cfg_mode)
    else $error("access taken during power-on hold-off");

  a_id_read_fixed: assert property (
    data_rd && index_q == CRB_IDX_ID |=> io_rdata_valid && io_rdata == PART_ID)
    else $error("identification byte wrong");

  a_rev_read_fixed: assert property (
    data_rd && index_q == CRB_IDX_REV |=> io_rdata == PART_REV)
    else $error("revision byte wrong");

  a_base_lo_strap: assert property (
    host_hard_reset_in |=>
      config_port_base[7:0] == ($past(base_select_strap) ? 8'h70 : 8'hF0))
    else $error("port base low byte not set from strap");

  a_base_hi_keep: assert property (
    (soft_q || vtr_por_in) && !host_hard_reset_in && !por_pend_q
      |=> $stable(config_port_base[15:8]))
    else $error("port base high byte changed by soft or standby reset");

  a_base_hi_hard: assert property (
    host_hard_reset_in |=> config_port_base[15:8] == 8'h03)
    else $error("port base high byte not reset");

  a_fio_base_rst: assert property (
    soft_q || vtr_por_in || host_hard_reset_in |=> floppy_io_base == 16'h03F0)
    else $error("floppy base not reset");

  a_ld1_reads_zero: assert property (
    data_rd && reg_q[CRB_POS_LDN] == CRB_LD_RSVD && index_q >= 8'h30
      |=> io_rdata == 8'h00)
    else $error("reserved bank returned data");

  a_key_enter: assert property (
    !blk && cfg_key_wr && !cfg_mode && io_wdata == 8'h55 && !mode_clr
      |=> cfg_mode)
    else $error("enter key not honoured");

  a_soft_ldn: assert property (
    soft_q |=> reg_q[CRB_POS_LDN] == 8'h00 && reg_q[1] == $past(reg_q[1]))
    else $error("soft reset applied wrongly");

  a_unmapped_zero: assert property (
    data_rd && index_q == 8'h25 |=> io_rdata == 8'h00)
    else $error("unmapped index returned data");

  c_enter_mode: cover property ($rose(cfg_mode));
  c_soft_reset: cover property (soft_q);
  c_floppy_base_write: cover property (data_wr && index_q == CRB_IDX_FIO_LO ##1 !rvalid_q);
endmodule // crb_top

// file: test/crb_host_model.sv
// crb_host_model: host bus master model issuing single-cycle i/o strobes
`timescale 1ns/10ps
module crb_host_model (
  // clock
  input  wire logic        sys_clk,
  // host i/o cycle
  output logic [15:0] io_addr,
  output logic        aen,
  output logic        io_wr,
  output logic        io_rd,
  output logic [7:0]  io_wdata
);
  // idle bus at time zero
  initial begin
    io_addr  = 16'h0000;
    aen      = 1'b0;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end

  // ----------------------------------------------------------------------
  // one i/o cycle
  // ----------------------------------------------------------------------
  // launched at a falling edge and released at the next, so the strobe is
  // sampled by exactly one rising edge; released lines flip so that no
  // stale address or data can pass for a live one
  task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                     input logic wr, input logic dma);
    @(negedge sys_clk);
    io_addr  = a;
    io_wdata = d;
    aen      = dma;
    io_wr    = wr;
    io_rd    = ~wr;
    @(negedge sys_clk);
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    aen      = 1'b0;
    io_addr  = ~io_addr;
    io_wdata = ~io_wdata;
  endtask
endmodule // crb_host_model

// file: test/tb_config_register_bank_fdd.sv
// tb_config_register_bank_fdd: self-checking bench of the register bank
`timescale 1ns/10ps
module tb_config_register_bank_fdd;
  import crb_pkg::*;
  localparam int P = 8;  // shortened power-on hold-off
  localparam logic [7:0] ID = 8'h5A;  // arbitrary value
  localparam logic [7:0] REV = 8'h21;  // arbitrary value

  logic        sys_clk, rstn, hard_rst, vtr_por, strap;
  logic [15:0] io_addr, base, cfg_base, fio_base;
  logic        aen, io_wr, io_rd, valid, cfg_mode, blocked, f_act;
  logic [7:0]  io_wdata, io_rdata, irq_sel, dma_sel, v;
  logic [7:0]  exp_q[$];
  int          n_errors, n_compared, k;

  crb_host_model u_host (.sys_clk(sys_clk), .io_addr(io_addr), .aen(aen), .io_wr(io_wr),
                         .io_rd(io_rd), .io_wdata(io_wdata));
  crb_top #(.POR_BLOCK_CYCLES(P), .PART_ID(ID), .PART_REV(REV)) u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .host_hard_reset_in(hard_rst), .vtr_por_in(vtr_por),
    .base_select_strap(strap), .io_addr(io_addr), .aen(aen), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(valid), .cfg_mode(cfg_mode),
    .host_blocked(blocked), .config_port_base(cfg_base), .floppy_unit_active(f_act),
    .floppy_io_base(fio_base), .floppy_irq_select(irq_sel), .floppy_dma_select(dma_sel));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.cyc(a, d, 1'b1, 1'b0);
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(base, idx);
    wr(base + 16'h0001, d);
  endtask

  // the expected byte is noted before the strobe goes out
  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    wr(base, idx);
    exp_q.push_back(exp);
    u_host.cyc(base + 16'h0001, 8'h00, 1'b0, 1'b0);
  endtask

  // one-cycle reset pulse: standby power-on when set, hard reset otherwise
  task automatic pulse(input bit standby);
    @(negedge sys_clk);
    if (standby) vtr_por = 1'b1;
    else hard_rst = 1'b1;
    @(negedge sys_clk);
    hard_rst = 1'b0;
    vtr_por = 1'b0;
    @(negedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // clock, read monitor and watchdog
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // a valid pulse with nothing expected means a refused access answered
  always @(negedge sys_clk) begin
    if (valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("mismatch at %0t: unexpected read answer", $time);
      end else
        check({8'h00, io_rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  initial begin
    #(25 * 4000);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h9fd6));
    strap = 1'($urandom);
    rstn = 1'b0;
    hard_rst = 1'b0;
    vtr_por = 1'b0;
    n_errors = 0;
    n_compared = 0;
    base = {8'h03, strap ? 8'h70 : 8'hF0};
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    // hold-off: a key written now must be dropped
    wr(base, CRB_KEY_ENTER);
    check(cfg_mode, 1'b0);
    k = 0;
    while (blocked === 1'b1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    check(k >= P - 3 && k <= P + 1, 1'b1);
    check(cfg_base, base);
    check(fio_base, 16'h03F0);
    $display("test power-on done");

    // dma cycle ignored, then key entry and index pointer read back
    u_host.cyc(base, CRB_KEY_ENTER, 1'b1, 1'b1);
    check(cfg_mode, 1'b0);
    wr(base, CRB_KEY_ENTER);
    check(cfg_mode, 1'b1);
    wr(base, 8'h61);
    exp_q.push_back(8'h61);
    u_host.cyc(base, 8'h00, 1'b0, 1'b0);
    $display("test entry done");

    // reset values of every mapped index, then fixed and unmapped places
    for (int i = 0; i < CRB_NREG; i++)
      reg_rd(CRB_REG_IDX[i], CRB_REG_IDX[i] == CRB_IDX_CTRL ? 8'h00 :
             CRB_REG_IDX[i] == CRB_IDX_BASE_LO ? base[7:0] : CRB_REG_RST[i]);
    reg_wr(CRB_IDX_ID, 8'hFF);
    reg_wr(CRB_IDX_REV, 8'hFF);
    reg_wr(8'h25, 8'hFF);
    reg_rd(CRB_IDX_ID, ID);
    reg_rd(CRB_IDX_REV, REV);
    reg_rd(8'h25, 8'h00);
    $display("test reset values done");

    // random writes to plain read/write registers read back
    for (int i = 3; i < CRB_NREG; i++) begin
      if (i == CRB_POS_BASE_LO || i == CRB_POS_BASE_HI) continue;
      v = 8'($urandom);
      reg_wr(CRB_REG_IDX[i], v);
      reg_rd(CRB_REG_IDX[i], v);
      if (i == CRB_POS_FIO_LO) check(fio_base[7:0], v);
      if (i == CRB_POS_IRQ) check(irq_sel, v);
      if (i == CRB_POS_DMA) check(dma_sel, v);
      if (i == CRB_POS_ACT) check(f_act, v[0]);
    end
    reg_wr(CRB_IDX_FIO_HI, 8'h02);
    reg_wr(CRB_IDX_FIO_LO, 8'hE8);
    reg_wr(8'h23, 8'h5C);
    check(fio_base, 16'h02E8);
    $display("test read write done");

    // reserved bank 1: reads zero, writes dropped
    reg_wr(CRB_IDX_LDN, CRB_LD_RSVD);
    reg_rd(CRB_IDX_FIO_HI, 8'h00);
    reg_wr(CRB_IDX_FIO_HI, 8'h07);
    check(fio_base, 16'h02E8);
    reg_wr(CRB_IDX_LDN, CRB_LD_FLOPPY);
    reg_rd(CRB_IDX_FIO_HI, 8'h02);
    $display("test reserved bank done");

    // soft reset: floppy base and device number back, index 0x23 kept
    reg_wr(CRB_IDX_LDN, CRB_LD_RSVD);
    reg_wr(CRB_IDX_CTRL, 8'h01);
    repeat (2) @(negedge sys_clk);
    check(fio_base, 16'h03F0);
    check(cfg_mode, 1'b1);
    reg_rd(CRB_IDX_LDN, 8'h00);
    reg_rd(CRB_IDX_CTRL, 8'h00);
    reg_rd(8'h23, 8'h5C);
    $display("test soft reset done");

    // exit key: data port refused, no answer expected
    wr(base, CRB_KEY_EXIT);
    check(cfg_mode, 1'b0);
    u_host.cyc(base + 16'h0001, 8'h00, 1'b0, 1'b0);
    $display("test exit done");

    // hard reset keeps the test registers, standby power-on clears them
    wr(base, CRB_KEY_ENTER);
    reg_wr(8'h2B, 8'h3C);
    reg_wr(CRB_IDX_BASE_HI, 8'h02);
    check(cfg_base, {8'h02, base[7:0]});
    base = cfg_base;
    pulse(1'b0);
    check(cfg_mode, 1'b0);
    base = {8'h03, strap ? 8'h70 : 8'hF0};
    check(cfg_base, base);
    wr(base, CRB_KEY_ENTER);
    reg_rd(8'h2B, 8'h3C);
    reg_wr(CRB_IDX_BASE_HI, 8'h02);
    base = {8'h02, base[7:0]};
    pulse(1'b1);
    check(cfg_base, base);
    wr(base, CRB_KEY_ENTER);
    reg_rd(8'h2B, 8'h00);
    reg_rd(CRB_IDX_FIO_LO, 8'hF0);
    $display("test hard and standby reset done");
    // let the monitor take the last answer before the queue is judged
    repeat (2) @(negedge sys_clk);
    check(16'(exp_q.size()), 16'd0);
    stop_test();
  end
endmodule // tb_config_register_bank_fdd
